// [oag_pkg.sv]
// package: constants, modes and carriers of the operand address generator
// Summary of operation
// - branch via AX loads program counter
// - multiply A by register, product into AX
// - word divide uses AX, quotient into AX
// - decimal adjusts operate on A implicitly
// - digit rotates hold digit data in A
// - 3-bit register code within selected bank
// - codes map X,A,C,B,E,D,L,H and AX..HL
// - direct mode uses 16-bit immediate address
// - short direct maps immediate into FE20H..FF1FH
// - short direct words only at even addresses
// - sfr mode excludes FFD0H..FFDFH
// - sfr words only at even addresses
// - indirect uses DE or HL of bank
// - HL plus zero-extended byte, carry dropped
// - HL plus B or C, carry dropped
// - stack uses SP, high-speed RAM only
// - bank area served from selected bank
package oag_pkg;

  // ----------------------------------------------------------------
  // address map constants
  // ----------------------------------------------------------------
  localparam logic [15:0] SHORT_BASE_ADDR = 16'hFE00; // short direct page base
  localparam logic [7:0] SHORT_WRAP_IMM = 8'h20; // below this bit 8 is set
  localparam logic [15:0] SFR_BASE_ADDR = 16'hFF00; // sfr page base
  localparam logic [15:0] SFR_HOLE_LO = 16'hFFD0; // first excluded sfr address
  localparam logic [15:0] SFR_HOLE_HI = 16'hFFDF; // last excluded sfr address
  localparam logic [15:0] HSRAM_LO = 16'hFB00; // lowest high-speed ram byte
  localparam logic [15:0] HSRAM_HI = 16'hFEFF; // highest high-speed ram byte
  localparam logic [15:0] BANK_AREA_LO = 16'h8000; // first banked address
  localparam logic [15:0] BANK_AREA_HI = 16'hBFFF; // last banked address

  // ----------------------------------------------------------------
  // register codes and reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] REG_X = 3'h0; // absolute register 0
  localparam logic [2:0] REG_A = 3'h1; // absolute register 1
  localparam logic [2:0] REG_C = 3'h2; // absolute register 2
  localparam logic [2:0] REG_B = 3'h3; // absolute register 3
  localparam logic [1:0] PAIR_AX = 2'h0; // pair 0
  localparam logic [1:0] PAIR_DE = 2'h2; // pair 2
  localparam logic [1:0] PAIR_HL = 2'h3; // pair 3
  localparam logic [7:0] GPR_RESET = 8'h00; // register file reset value
  localparam logic [15:0] PC_RESET = 16'h0000; // program counter output reset
  localparam logic [7:0] DAA_LO_FIX = 8'h06; // decimal adjust low digit step
  localparam logic [7:0] DAA_HI_FIX = 8'h60; // decimal adjust high digit step
  localparam logic [3:0] DIGIT_MAX = 4'h9; // largest decimal digit
  localparam logic [7:0] BYTE_MAX_BCD = 8'h99; // largest two-digit decimal

  // ----------------------------------------------------------------
  // addressing modes
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    OAG_NONE = 4'b0000,
    OAG_BR_AX = 4'b0001,
    OAG_UNSIGNED_MULTIPLY_INSN = 4'b0010,
    OAG_UNSIGNED_WORD_DIVIDE_INSN = 4'b0011,
    OAG_ADJ_ADD = 4'b0100,
    OAG_ADJ_SUB = 4'b0101,
    OAG_ROT_R = 4'b0110,
    OAG_ROT_L = 4'b0111,
    OAG_REG = 4'b1000,
    OAG_DIRECT = 4'b1001,
    OAG_SHORT = 4'b1010,
    OAG_SFR = 4'b1011,
    OAG_INDIRECT = 4'b1100,
    OAG_BASED = 4'b1101,
    OAG_BASED_IDX = 4'b1110,
    OAG_STACK = 4'b1111
  } oag_mode_t;

  // decoded instruction fields for one execute cycle
  typedef struct packed {
    oag_mode_t mode; // addressing mode
    logic [2:0] r_code; // 8-bit register code
    logic [1:0] rp_code; // register pair code
    logic [7:0] imm8; // byte immediate or offset
    logic [15:0] imm16; // direct address immediate
    logic word; // word access when set
    logic idx_c; // based indexed uses C when set, B when clear
    logic half_carry; // decimal adjust auxiliary carry
    logic carry; // decimal adjust carry
    logic [7:0] mem_rdata; // memory byte for digit rotate
  } oag_req_t;

  // memory and sfr access presented to the access path
  typedef struct packed {
    logic valid; // access present this cycle
    logic [15:0] addr; // effective address
    logic word; // word access when set
    logic sfr; // target is sfr space
    logic bank_hit; // address lies in bank area
    logic [2:0] bank; // bank number for bank area
    logic write; // carries write data
    logic [7:0] wdata; // write byte
  } oag_acc_t;

endpackage

// [oag_zx_adder.sv]
// module: 16-bit base plus zero-extended byte offset, carry dropped
`timescale 1ns/1ps
module oag_zx_adder (
  // operands
  input wire logic [15:0] base_i,
  input wire logic [7:0] offset_i,
  // result
  output logic [15:0] sum_o
);

  // ----------------------------------------------------------------
  // addition
  // ----------------------------------------------------------------
  // offset widened as positive number, bit 16 of the sum is discarded
  assign sum_o = base_i + {8'h00, offset_i};

endmodule // oag_zx_adder

// [oag_gpr_file.sv]
// module: four banks of eight 8-bit general registers
`timescale 1ns/1ps
module oag_gpr_file (
  // clock and reset
  input wire logic mclk_i,
  input wire logic arst_n_i,
  // bank select
  input wire logic [1:0] bank_i,
  // byte write port
  input wire logic byte_we_i,
  input wire logic [2:0] byte_code_i,
  input wire logic [7:0] byte_data_i,
  // pair write port, wins over byte port
  input wire logic pair_we_i,
  input wire logic [1:0] pair_code_i,
  input wire logic [15:0] pair_data_i,
  // whole selected bank, register n at bits 8n+7..8n
  output logic [63:0] bank_o
);

  logic [7:0] gpr_reg [0:31]; // register storage, index {bank, code}

  // ----------------------------------------------------------------
  // storage update
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int i = 0; i < 32; i++) begin
        gpr_reg[i] <= oag_pkg::GPR_RESET;
      end
    end else if (pair_we_i) begin
      // pair n is low byte 2n, high byte 2n+1
      gpr_reg[{bank_i, pair_code_i, 1'b0}] <= pair_data_i[7:0];
      gpr_reg[{bank_i, pair_code_i, 1'b1}] <= pair_data_i[15:8];
    end else if (byte_we_i) begin
      gpr_reg[{bank_i, byte_code_i}] <= byte_data_i;
    end
  end

  // ----------------------------------------------------------------
  // bank read view
  // ----------------------------------------------------------------
  always_comb begin
    for (int j = 0; j < 8; j++) begin
      bank_o[j*8 +: 8] = gpr_reg[{bank_i, 3'(j)}];
    end
  end

endmodule // oag_gpr_file

// [oag_agen.sv]
// module: operand address generation and implied accumulator operations
`timescale 1ns/1ps
module oag_agen (
  // clock and reset
  input wire logic mclk_i,
  input wire logic arst_n_i,
  // decoded request, one execute cycle per valid
  input wire logic req_valid_i,
  input wire oag_pkg::oag_req_t req_i,
  // bank selection state
  input wire logic register_bank_sel_lo_i,
  input wire logic register_bank_sel_hi_i,
  input wire logic [2:0] mem_bank_sel_i,
  // stack pointer
  input wire logic [15:0] sp_i,
  // core write port into the register file
  input wire logic gpr_we_i,
  input wire logic [2:0] gpr_code_i,
  input wire logic [7:0] gpr_data_i,
  // access toward memory and sfr space
  output oag_pkg::oag_acc_t acc_o,
  // branch target
  output logic pc_load_o,
  output logic [15:0] pc_o,
  // operand byte for register mode
  output logic [7:0] reg_operand_o,
  // illegal access was refused
  output logic fault_o
);

  // ----------------------------------------------------------------
  // register file view
  // ----------------------------------------------------------------
  logic [1:0] rbank; // selected register bank
  logic [63:0] bank_view; // all eight registers of selected bank
  logic [7:0] reg_a; // accumulator
  logic [7:0] reg_x; // register x
  logic [7:0] reg_b; // register b
  logic [7:0] reg_c; // register c
  logic [7:0] reg_r; // register chosen by r code
  logic [15:0] pair_ax; // pair ax
  logic [15:0] pair_de; // pair de
  logic [15:0] pair_hl; // pair hl
  logic [15:0] pair_rp; // pair chosen by rp code

  assign rbank = {register_bank_sel_hi_i, register_bank_sel_lo_i};
  assign reg_x = bank_view[oag_pkg::REG_X*8 +: 8];
  assign reg_a = bank_view[oag_pkg::REG_A*8 +: 8];
  assign reg_c = bank_view[oag_pkg::REG_C*8 +: 8];
  assign reg_b = bank_view[oag_pkg::REG_B*8 +: 8];
  assign reg_r = bank_view[req_i.r_code*8 +: 8];
  assign pair_ax = bank_view[oag_pkg::PAIR_AX*16 +: 16];
  assign pair_de = bank_view[oag_pkg::PAIR_DE*16 +: 16];
  assign pair_hl = bank_view[oag_pkg::PAIR_HL*16 +: 16];
  assign pair_rp = bank_view[req_i.rp_code*16 +: 16];

  // ----------------------------------------------------------------
  // implied accumulator arithmetic
  // ----------------------------------------------------------------
  logic [15:0] mul_product; // a times register operand
  logic [15:0] div_quot; // ax divided by register operand
  logic [7:0] adj_step; // decimal correction amount
  logic [7:0] adj_value; // corrected accumulator
  logic [7:0] rot_a; // accumulator after digit rotate
  logic [7:0] rot_mem; // memory byte after digit rotate

  // unsigned 8 x 8 multiply, a is the implied multiplicand
  assign mul_product = {8'h00, reg_a} * {8'h00, reg_r};

  // ax is the implied dividend, divide by zero yields all ones
  always_comb begin
    if (reg_r == 8'h00) begin
      div_quot = 16'hFFFF;
    end else begin
      div_quot = pair_ax / {8'h00, reg_r};
    end
  end

  // decimal correction of a after add or subtract
  always_comb begin
    adj_step = 8'h00;
    if (reg_a[3:0] > oag_pkg::DIGIT_MAX || req_i.half_carry) begin
      adj_step = adj_step | oag_pkg::DAA_LO_FIX;
    end
    if (reg_a > oag_pkg::BYTE_MAX_BCD || req_i.carry) begin
      adj_step = adj_step | oag_pkg::DAA_HI_FIX;
    end
    if (req_i.mode == oag_pkg::OAG_ADJ_SUB) begin
      adj_value = reg_a - adj_step;
    end else begin
      adj_value = reg_a + adj_step;
    end
  end

  // digit rotate through the low digit of a and the byte at hl
  always_comb begin
    if (req_i.mode == oag_pkg::OAG_ROT_L) begin
      rot_a = {reg_a[7:4], req_i.mem_rdata[7:4]};
      rot_mem = {req_i.mem_rdata[3:0], reg_a[3:0]};
    end else begin
      rot_a = {reg_a[7:4], req_i.mem_rdata[3:0]};
      rot_mem = {reg_a[3:0], req_i.mem_rdata[7:4]};
    end
  end

  // ----------------------------------------------------------------
  // register file write selection
  // ----------------------------------------------------------------
  logic pair_we; // implied pair result
  logic [15:0] pair_wdata; // pair result data
  logic byte_we; // byte result or core write
  logic [2:0] byte_code; // byte write target
  logic [7:0] byte_wdata; // byte write data
  logic exec_unsigned_multiply_insn; // multiply in execute
  logic exec_unsigned_word_divide_insn; // divide in execute
  logic exec_adj; // decimal adjust in execute
  logic exec_rot; // digit rotate in execute

  assign exec_unsigned_multiply_insn = req_valid_i && req_i.mode == oag_pkg::OAG_UNSIGNED_MULTIPLY_INSN;
  assign exec_unsigned_word_divide_insn = req_valid_i && req_i.mode == oag_pkg::OAG_UNSIGNED_WORD_DIVIDE_INSN;
  assign exec_adj = req_valid_i && (req_i.mode == oag_pkg::OAG_ADJ_ADD
                    || req_i.mode == oag_pkg::OAG_ADJ_SUB);
  assign exec_rot = req_valid_i && (req_i.mode == oag_pkg::OAG_ROT_R
                    || req_i.mode == oag_pkg::OAG_ROT_L);

  // implied results go to a or ax, the core port fills in otherwise
  always_comb begin
    pair_we = exec_unsigned_multiply_insn || exec_unsigned_word_divide_insn;
    pair_wdata = exec_unsigned_multiply_insn ? mul_product : div_quot;
    byte_we = gpr_we_i;
    byte_code = gpr_code_i;
    byte_wdata = gpr_data_i;
    if (exec_adj) begin
      byte_we = 1'b1;
      byte_code = oag_pkg::REG_A;
      byte_wdata = adj_value;
    end else if (exec_rot) begin
      byte_we = 1'b1;
      byte_code = oag_pkg::REG_A;
      byte_wdata = rot_a;
    end
  end

  oag_gpr_file u_gpr (
    .mclk_i(mclk_i),
    .arst_n_i(arst_n_i),
    .bank_i(rbank),
    .byte_we_i(byte_we),
    .byte_code_i(byte_code),
    .byte_data_i(byte_wdata),
    .pair_we_i(pair_we),
    .pair_code_i(oag_pkg::PAIR_AX),
    .pair_data_i(pair_wdata),
    .bank_o(bank_view)
  );

  // ----------------------------------------------------------------
  // effective address formation
  // ----------------------------------------------------------------
  logic [15:0] based_sum; // hl plus byte offset
  logic [15:0] index_sum; // hl plus b or c
  logic [15:0] short_addr; // short direct address
  logic [15:0] sfr_addr; // sfr address
  logic [15:0] ea; // effective address
  logic ea_valid; // mode makes a memory or sfr access
  logic ea_sfr; // target lies in sfr space
  logic ea_fault; // access refused

  oag_zx_adder u_based (
    .base_i(pair_hl),
    .offset_i(req_i.imm8),
    .sum_o(based_sum)
  );

  oag_zx_adder u_index (
    .base_i(pair_hl),
    .offset_i(req_i.idx_c ? reg_c : reg_b),
    .sum_o(index_sum)
  );

  // bit 8 set only for immediates below the wrap point
  assign short_addr = oag_pkg::SHORT_BASE_ADDR
                      | {7'h00, req_i.imm8 < oag_pkg::SHORT_WRAP_IMM, req_i.imm8};
  assign sfr_addr = oag_pkg::SFR_BASE_ADDR | {8'h00, req_i.imm8};

  // one address per mode, with alignment and range checks
  always_comb begin
    ea = 16'h0000;
    ea_valid = 1'b0;
    ea_sfr = 1'b0;
    ea_fault = 1'b0;
    unique case (req_i.mode)
      oag_pkg::OAG_DIRECT: begin
        ea = req_i.imm16;
        ea_valid = 1'b1;
        ea_sfr = req_i.imm16 >= oag_pkg::SFR_BASE_ADDR;
      end
      oag_pkg::OAG_SHORT: begin
        ea = short_addr;
        ea_valid = 1'b1;
        ea_sfr = short_addr >= oag_pkg::SFR_BASE_ADDR;
        ea_fault = req_i.word && short_addr[0];
      end
      oag_pkg::OAG_SFR: begin
        ea = sfr_addr;
        ea_valid = 1'b1;
        ea_sfr = 1'b1;
        ea_fault = (sfr_addr >= oag_pkg::SFR_HOLE_LO && sfr_addr <= oag_pkg::SFR_HOLE_HI)
                   || (req_i.word && sfr_addr[0]);
      end
      oag_pkg::OAG_INDIRECT: begin
        ea = req_i.rp_code[0] ? pair_hl : pair_de;
        ea_valid = 1'b1;
        ea_sfr = ea >= oag_pkg::SFR_BASE_ADDR;
      end
      oag_pkg::OAG_BASED: begin
        ea = based_sum;
        ea_valid = 1'b1;
        ea_sfr = based_sum >= oag_pkg::SFR_BASE_ADDR;
      end
      oag_pkg::OAG_BASED_IDX: begin
        ea = index_sum;
        ea_valid = 1'b1;
        ea_sfr = index_sum >= oag_pkg::SFR_BASE_ADDR;
      end
      oag_pkg::OAG_STACK: begin
        ea = sp_i;
        ea_valid = 1'b1;
        ea_fault = sp_i < oag_pkg::HSRAM_LO || sp_i > oag_pkg::HSRAM_HI;
      end
      oag_pkg::OAG_ROT_R, oag_pkg::OAG_ROT_L: begin
        ea = pair_hl; // rotated byte is written back at hl
        ea_valid = 1'b1;
        ea_sfr = pair_hl >= oag_pkg::SFR_BASE_ADDR;
      end
      oag_pkg::OAG_NONE, oag_pkg::OAG_BR_AX, oag_pkg::OAG_UNSIGNED_MULTIPLY_INSN, oag_pkg::OAG_UNSIGNED_WORD_DIVIDE_INSN,
      oag_pkg::OAG_ADJ_ADD, oag_pkg::OAG_ADJ_SUB, oag_pkg::OAG_REG: begin
        ea_valid = 1'b0; // register-only modes make no access
      end
    endcase
  end

  // ----------------------------------------------------------------
  // access output register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      acc_o <= '0;
    end else begin
      acc_o.valid <= req_valid_i && ea_valid && !ea_fault;
      acc_o.addr <= ea;
      acc_o.word <= req_i.word && !exec_rot;
      acc_o.sfr <= ea_sfr;
      acc_o.bank_hit <= ea >= oag_pkg::BANK_AREA_LO && ea <= oag_pkg::BANK_AREA_HI;
      acc_o.bank <= mem_bank_sel_i;
      acc_o.write <= exec_rot;
      acc_o.wdata <= exec_rot ? rot_mem : 8'h00; // write byte only beside a write
    end
  end

  // ----------------------------------------------------------------
  // fault flag, one cycle per refused access
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      fault_o <= 1'b0;
    end else begin
      fault_o <= req_valid_i && ea_valid && ea_fault;
    end
  end

  // ----------------------------------------------------------------
  // branch through ax
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pc_load_o <= 1'b0;
      pc_o <= oag_pkg::PC_RESET;
    end else begin
      pc_load_o <= req_valid_i && req_i.mode == oag_pkg::OAG_BR_AX;
      if (req_valid_i && req_i.mode == oag_pkg::OAG_BR_AX) begin
        pc_o <= pair_ax;
      end
    end
  end

  // ----------------------------------------------------------------
  // register operand capture
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      reg_operand_o <= 8'h00;
    end else if (req_valid_i && req_i.mode == oag_pkg::OAG_REG) begin
      reg_operand_o <= req_i.word ? pair_rp[7:0] : reg_r;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [15:0] chk_ax_prev; // ax before the last edge
  logic [15:0] chk_mul_prev; // product formed before the last edge
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      chk_ax_prev <= 16'h0000;
      chk_mul_prev <= 16'h0000;
    end else begin
      chk_ax_prev <= pair_ax;
      chk_mul_prev <= {8'h00, reg_a} * {8'h00, reg_r};
    end
  end

  a_br_ax_target: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    req_valid_i && req_i.mode == oag_pkg::OAG_BR_AX |=> pc_load_o && pc_o == chk_ax_prev)
    else $error("branch target differs from ax");

  a_unsigned_multiply_insn_product: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    exec_unsigned_multiply_insn |=> pair_ax == chk_mul_prev)
    else $error("multiply product not in ax");

  a_unsigned_word_divide_insn_quot: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    exec_unsigned_word_divide_insn && reg_r != 8'h00 |=> pair_ax == $past(pair_ax) / {8'h00, $past(reg_r)})
    else $error("divide quotient not in ax");

  a_direct_addr: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    req_valid_i && req_i.mode == oag_pkg::OAG_DIRECT |=> acc_o.valid
    && acc_o.addr == $past(req_i.imm16))
    else $error("direct address mismatch");

  a_short_window: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    req_valid_i && req_i.mode == oag_pkg::OAG_SHORT |=> acc_o.addr >= 16'hFE20
    && acc_o.addr <= 16'hFF1F && acc_o.addr[7:0] == $past(req_i.imm8))
    else $error("short direct address outside window");

  a_word_even: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    acc_o.valid && acc_o.word && (acc_o.addr >= 16'hFE20) && !acc_o.write
    && $past(req_i.mode == oag_pkg::OAG_SHORT || req_i.mode == oag_pkg::OAG_SFR)
    |-> !acc_o.addr[0])
    else $error("odd word access in short or sfr mode");

  a_sfr_hole: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    req_valid_i && req_i.mode == oag_pkg::OAG_SFR && req_i.imm8[7:4] == 4'hD
    |=> !acc_o.valid && fault_o)
    else $error("sfr hole was accessed");

  a_based_sum: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    req_valid_i && req_i.mode == oag_pkg::OAG_BASED
    |=> acc_o.addr == 16'($past(pair_hl) + {8'h00, $past(req_i.imm8)}))
    else $error("based address mismatch");

  a_stack_ram: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    req_valid_i && req_i.mode == oag_pkg::OAG_STACK
    |=> acc_o.valid == ($past(sp_i) >= oag_pkg::HSRAM_LO && $past(sp_i) <= oag_pkg::HSRAM_HI)
    && (!acc_o.valid || acc_o.addr == $past(sp_i)))
    else $error("stack access outside high-speed ram");

  a_bank_flag: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    acc_o.valid |-> acc_o.bank_hit == (acc_o.addr[15:14] == 2'b10))
    else $error("bank area flag wrong");

endmodule // oag_agen

// [oag_mem_model.sv]
// partner model: byte store standing for internal memory and sfr space
`timescale 1ns/1ps
module oag_mem_model (
  // clock and access from the generator
  input wire logic mclk_i,
  input wire oag_pkg::oag_acc_t acc_i,
  // read port used to supply operand bytes
  input wire logic [15:0] addr_i,
  output logic [7:0] rdata_o
);
  logic [7:0] mem [65536]; // byte space, starts cleared
  initial for (int k = 0; k < 65536; k++) mem[k] = 8'h00;
  // one effective address plus size per access; only writes change the store
  always @(posedge mclk_i) begin
    if (acc_i.valid && acc_i.write) mem[acc_i.addr] <= acc_i.wdata;
  end
  assign rdata_o = mem[addr_i];
endmodule // oag_mem_model

// [test_oag_agen.sv]
// testbench: random requests checked against a register and address model
`timescale 1ns/1ps
module test_oag_agen;
  logic mclk_i = 1'b0, arst_n_i = 1'b0, req_valid_i = 1'b0, gpr_we_i = 1'b0;
  logic register_bank_sel_lo_i = 1'b0, register_bank_sel_hi_i = 1'b0;
  logic [2:0] mem_bank_sel_i = 3'h0, gpr_code_i = 3'h0;
  logic [7:0] gpr_data_i = 8'h00, reg_operand_o, rd, opx, st;
  logic [15:0] sp_i = 16'h0000, pc_o, ea, pcx, hl;
  oag_pkg::oag_req_t req_i = '0;
  oag_pkg::oag_acc_t acc_o, e;
  logic pc_load_o, fault_o, ef, ep, am;
  logic [7:0] gpr [4][8]; // model of the four register banks
  logic [63:0] t;
  int n_fail = 0, checks = 0, seed = 50, i, k, b, r;
  int mv[15] = '{1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 14, 15}; // modes exercised
  // --------------------------------------------------------------
  // design, partner and clock
  // --------------------------------------------------------------
  oag_agen uut (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .req_valid_i(req_valid_i),
    .req_i(req_i), .register_bank_sel_lo_i(register_bank_sel_lo_i),
    .register_bank_sel_hi_i(register_bank_sel_hi_i), .mem_bank_sel_i(mem_bank_sel_i),
    .sp_i(sp_i), .gpr_we_i(gpr_we_i), .gpr_code_i(gpr_code_i), .gpr_data_i(gpr_data_i),
    .acc_o(acc_o), .pc_load_o(pc_load_o), .pc_o(pc_o), .reg_operand_o(reg_operand_o),
    .fault_o(fault_o));
  oag_mem_model mem (.mclk_i(mclk_i), .acc_i(acc_o), .addr_i(hl), .rdata_o(rd));
  initial forever #5 mclk_i = ~mclk_i;
  // register pair n of bank bb, low byte at code 2n
  function automatic logic [15:0] pr(int bb, int n);
    return {gpr[bb][2*n+1], gpr[bb][2*n]};
  endfunction
  task automatic cmp_acc(input oag_pkg::oag_acc_t g, input oag_pkg::oag_acc_t x);
    checks++;
    if (g !== x) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  task automatic cmp_val(input logic [15:0] g, input logic [15:0] x);
    checks++;
    if (g !== x) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  task automatic print_verdict;
    if (n_fail == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // --------------------------------------------------------------
  // main sequence: one register write, then one request, per round
  // --------------------------------------------------------------
  initial begin
    foreach (gpr[x, y]) gpr[x][y] = 8'h00;
    repeat (2) @(negedge mclk_i);
    arst_n_i = 1'b1;
    for (i = 0; i < 600; i++) begin
      @(negedge mclk_i);
      if (i == 300) begin
        arst_n_i = 1'b0; // second reset mid-run clears the banks
        foreach (gpr[x, y]) gpr[x][y] = 8'h00;
        @(negedge mclk_i);
        arst_n_i = 1'b1;
        cmp_val(acc_o.valid | pc_load_o | fault_o, 16'h0000);
      end
      r = $random(seed);
      b = r[15:14];
      {register_bank_sel_hi_i, register_bank_sel_lo_i} = r[15:14];
      mem_bank_sel_i = r[13:11];
      sp_i = {5'h1F, r[10:0]}; // spans inside and outside high-speed ram
      gpr_we_i = 1'b1;
      gpr_code_i = r[18:16];
      gpr_data_i = r[26:19];
      gpr[b][r[18:16]] = r[26:19];
      hl = pr(b, 3); // byte at hl settles on rd for the digit rotates
      @(negedge mclk_i);
      gpr_we_i = 1'b0;
      t = {$random(seed), $random(seed)};
      k = {$random(seed)} % 15;
      req_i = t[44:0];
      req_i.mode = oag_pkg::oag_mode_t'(mv[k]);
      req_i.mem_rdata = rd;
      if (mv[k] < 9) req_i.word = 1'b0;
      req_valid_i = 1'b1;
      // expected outcome from the bank model before implied writes
      e = '0;
      ef = 1'b0;
      ep = 1'b0;
      am = mv[k] >= 9 || mv[k] == 6 || mv[k] == 7;
      ea = 16'h0000;
      pcx = pr(b, 0);
      opx = gpr[b][req_i.r_code];
      case (req_i.mode)
        oag_pkg::OAG_DIRECT: ea = req_i.imm16;
        oag_pkg::OAG_SHORT: begin
          ea = 16'hFE00 + {8'h00, req_i.imm8} + (req_i.imm8 < 8'h20 ? 16'h0100 : 16'h0000);
          ef = req_i.word & req_i.imm8[0];
        end
        oag_pkg::OAG_SFR: begin
          ea = {8'hFF, req_i.imm8};
          ef = (req_i.imm8[7:4] == 4'hD) | (req_i.word & req_i.imm8[0]);
        end
        oag_pkg::OAG_INDIRECT: ea = pr(b, req_i.rp_code[0] ? 3 : 2);
        oag_pkg::OAG_BASED: ea = hl + {8'h00, req_i.imm8};
        oag_pkg::OAG_BASED_IDX: ea = hl + {8'h00, req_i.idx_c ? gpr[b][2] : gpr[b][3]};
        oag_pkg::OAG_STACK: begin
          ea = sp_i;
          ef = sp_i < 16'hFB00 || sp_i > 16'hFEFF;
        end
        oag_pkg::OAG_BR_AX: ep = 1'b1;
        oag_pkg::OAG_UNSIGNED_MULTIPLY_INSN: {gpr[b][1], gpr[b][0]} = gpr[b][1] * gpr[b][req_i.r_code];
        oag_pkg::OAG_UNSIGNED_WORD_DIVIDE_INSN: {gpr[b][1], gpr[b][0]} = (opx == 8'h00) ? 16'hFFFF : pcx / opx;
        oag_pkg::OAG_ADJ_ADD, oag_pkg::OAG_ADJ_SUB: begin
          st = ((gpr[b][1][3:0] > 4'h9 || req_i.half_carry) ? 8'h06 : 8'h00)
               | ((gpr[b][1] > 8'h99 || req_i.carry) ? 8'h60 : 8'h00);
          gpr[b][1] = (req_i.mode == oag_pkg::OAG_ADJ_SUB) ? gpr[b][1] - st : gpr[b][1] + st;
        end
        oag_pkg::OAG_ROT_R, oag_pkg::OAG_ROT_L: begin
          // mode bit 0 set for the left rotate
          ea = hl;
          e.write = 1'b1;
          e.wdata = req_i.mode[0] ? {req_i.mem_rdata[3:0], gpr[b][1][3:0]}
                    : {gpr[b][1][3:0], req_i.mem_rdata[7:4]};
          opx = req_i.mode[0] ? {4'h0, req_i.mem_rdata[7:4]} : {4'h0, req_i.mem_rdata[3:0]};
          gpr[b][1] = {gpr[b][1][7:4], opx[3:0]};
          opx = gpr[b][req_i.r_code];
        end
        default: ;
      endcase
      e.valid = am & ~ef;
      e.addr = ea;
      e.word = req_i.word;
      e.sfr = ea >= 16'hFF00;
      e.bank_hit = ea >= 16'h8000 && ea <= 16'hBFFF;
      e.bank = mem_bank_sel_i;
      @(negedge mclk_i);
      req_valid_i = 1'b0;
      if (e.valid) cmp_acc(acc_o, e);
      else cmp_val(acc_o.valid, 16'h0000);
      cmp_val(fault_o, ef);
      cmp_val(pc_load_o, ep);
      if (ep) cmp_val(pc_o, pcx);
      if (mv[k] == 8) cmp_val(reg_operand_o, opx);
    end
    print_verdict();
  end
endmodule // test_oag_agen
